// >>> logic/acsrc_top.v
// Converter sequencer and result capture with memory-mapped registers.
`timescale 1ns/1ns
`include "acsrc_regs.vh"
module acsrc_top (
   // Clock and reset.
   input  wire        clk,
   input  wire        reset,
   // Start sources (asynchronous pins).
   input  wire        pwm_period_sync,
   input  wire        external_start_pin,
   // Data memory port.
   input  wire        dm_sel,
   input  wire        dm_wr,
   input  wire [3:0]  dm_addr,
   input  wire [15:0] dm_wdata,
   output reg  [15:0] dm_rdata,
   // Analog front end control.
   output reg         hold_a,
   output reg         hold_b,
   output reg  [1:0]  mux_pair_sel,
   output reg         mux_bank_b,
   output reg         core_feed,
   output wire [1:0]  front_mode,
   // Converter core raw output, sampled with core_feed.
   input  wire [11:0] core_code,
   input  wire        core_range_fault,
   // Interrupt request toward interrupt_controller_block.
   output reg         conv_irq
);
   // Sequencer states.
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN  = 2'h1;
   localparam ST_WAIT = 2'h2;

   // Pin synchronisers.
   reg [1:0] pwm_sync_reg;
   reg [1:0] ext_sync_reg;
   reg       start_prev_reg;
   // Registers.
   reg [15:0] control_reg;
   reg [15:0] result_reg [0:7];
   reg [15:0] track_reg;
   reg [7:0]  faults_reg;
   reg [4:0]  status_reg;
   // Sequencer.
   reg [1:0]  state_reg;
   reg [3:0]  feed_cnt_reg;
   reg        pending_reg;
   integer    k;

   wire        tick;
   wire        pipe_valid;
   wire [12:0] pipe_word;
   wire [3:0]  pipe_tag;
   reg         feed_valid;
   reg  [3:0]  feed_tag;

   // Pack a raw 12-bit code left-aligned with zero low nibble.
   function [15:0] left_align;
      input [11:0] code;
      begin
         left_align = {code, 4'h0}; // [RULE1] [RULE2]
      end
   endfunction

   // Input converted in feed slot n: 0..7 in sequential mode, else input n/2 then n/2+4.
   function [2:0] chan_of;
      input [2:0] slot;
      input       seq;
      begin
         chan_of = seq ? slot : {slot[0], slot[2:1]}; // [RULE8]
      end
   endfunction

   acsrc_clkdiv u_div (
      .clk       (clk),
      .reset     (reset),
      .phase_reg (),
      .tick      (tick)
   );

   acsrc_pipe u_pipe (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (feed_valid),
      .in_word   ({core_range_fault, core_code}),
      .in_tag    (feed_tag),
      .out_valid (pipe_valid),
      .out_word  (pipe_word),
      .out_tag   (pipe_tag)
   );

   assign front_mode = control_reg[`ACSRC_CTRL_MODE_HI:`ACSRC_CTRL_MODE_LO]; // [RULE6]

   // Selected start source after two-flop synchronisation.
   wire start_level = control_reg[`ACSRC_CTRL_SRC_BIT] ? ext_sync_reg[1]
                                                       : pwm_sync_reg[1]; // [RULE19]
   wire start_edge  = start_level & ~start_prev_reg;
   wire seq_mode    = (front_mode == `ACSRC_MODE_SEQ);
   // A start seen in idle launches at once; waiting for a tick would break the 49-cycle bound.
   wire launch      = (state_reg == ST_IDLE) && (start_edge || pending_reg); // [RULE15]
   // The multiplexer is set one slot ahead, so the input is steady when its slot feeds.
   wire [2:0] next_chan = chan_of(feed_cnt_reg[2:0] + 3'h1, seq_mode);

   // Synchronisers; the first flop feeds only the second.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         pwm_sync_reg   <= 2'h0;
         ext_sync_reg   <= 2'h0;
         start_prev_reg <= 1'b0;
      end else begin
         pwm_sync_reg   <= {pwm_sync_reg[0], pwm_period_sync};
         ext_sync_reg   <= {ext_sync_reg[0], external_start_pin};
         start_prev_reg <= start_level;
      end
   end

   // Control word written by the core; reset selects simultaneous mode, internal start.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         control_reg <= `ACSRC_CTRL_RESET; // [RULE7]
      end else if (dm_sel && dm_wr && dm_addr == `ACSRC_OFS_CTRL) begin
         control_reg <= dm_wdata & 16'h0019;
      end
   end

   // Sequence control. The pair is held on the start edge itself; a start seen while a
   // sequence runs is kept as pending and launched once the sequence has ended.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg      <= ST_IDLE;
         feed_cnt_reg   <= 4'h0;
         pending_reg    <= 1'b0;
         hold_a         <= 1'b0;
         hold_b         <= 1'b0;
         mux_pair_sel   <= 2'h0;
         mux_bank_b     <= 1'b0;
      end else begin
         if (start_edge && state_reg != ST_IDLE) begin
            pending_reg <= 1'b1;
         end else if (launch) begin
            pending_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               hold_a       <= 1'b0;
               hold_b       <= 1'b0;
               mux_pair_sel <= 2'h0;
               mux_bank_b   <= 1'b0;
               if (launch) begin
                  // Hold pair 0 at once: hold_a always, hold_b too except in sequential mode; first feed on next tick.
                  hold_a         <= 1'b1; // [RULE9]
                  hold_b         <= ~seq_mode;
                  feed_cnt_reg   <= 4'h0;
                  state_reg      <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (tick) begin
                  // Feed order per tick: input n then n+4 (0 to 7 in sequential mode); next pair selected every two ticks, every tick in sequential mode.
                  mux_pair_sel <= next_chan[1:0]; // [RULE8] [RULE11]
                  mux_bank_b   <= next_chan[2];   // [RULE17]
                  // Two slots per pair put successive pairs eight core cycles apart.
                  feed_cnt_reg <= feed_cnt_reg + 4'h1; // [RULE16]
                  if (feed_cnt_reg == 4'h7) begin
                     state_reg <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               hold_a <= 1'b0;
               hold_b <= 1'b0;
               if (pipe_valid && pipe_tag == 4'h7) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Core feed strobe: one core cycle per converter period, tagged with its channel.
   // Sequence channel index maps pair p, bank b to input p + 4*b.
   always @* begin
      feed_valid = 1'b0;
      feed_tag   = 4'h8;
      core_feed  = 1'b0;
      if (state_reg == ST_RUN && tick) begin
         feed_valid = 1'b1;
         core_feed  = 1'b1;
         feed_tag   = {1'b0, chan_of(feed_cnt_reg[2:0], seq_mode)}; // [RULE8]
      end else if (state_reg == ST_IDLE && tick && !launch) begin
         // Single channel tracking of input 0 between sequences.
         feed_valid = 1'b1;
         core_feed  = 1'b1;
         feed_tag   = 4'h8; // [RULE20]
      end
   end

   // Result capture as each word leaves the pipeline, tracking words only while idle; untouched registers keep old data.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         for (k = 0; k < 8; k = k + 1) begin
            result_reg[k] <= 16'h0000;
         end
         track_reg  <= 16'h0000;
         faults_reg <= 8'h00;
         status_reg <= 5'h00;
         conv_irq   <= 1'b0;
      end else begin
         conv_irq <= 1'b0;
         // Clear first, so a tracking fault arriving in the same cycle wins.
         if (launch) begin
            status_reg <= 5'h00; // [RULE13]
         end
         if (pipe_valid) begin
            if (pipe_tag[3]) begin
               if (state_reg == ST_IDLE) begin
                  track_reg <= left_align(pipe_word[11:0]); // [RULE20]
                  status_reg[`ACSRC_STAT_TRACK_FAULT] <= pipe_word[12];
               end
            end else begin
               result_reg[pipe_tag[2:0]] <= left_align(pipe_word[11:0]); // [RULE1] [RULE21]
               faults_reg[pipe_tag[2:0]] <= pipe_word[12]; // [RULE3] [RULE4]
               if (pipe_tag[2] && !seq_mode) begin
                  status_reg[pipe_tag[1:0]] <= 1'b1; // [RULE12]
               end
               if (pipe_tag[2:0] == 3'h7) begin
                  if (seq_mode) begin
                     status_reg[3:0] <= 4'hf;
                  end
                  conv_irq <= 1'b1; // [RULE14] [RULE15]
               end
            end
         end
      end
   end

   // Read data; unmapped offsets read zero. Software classifies faults from MSB.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         dm_rdata <= 16'h0000;
      end else if (dm_sel && !dm_wr) begin
         if (dm_addr < `ACSRC_OFS_TRACK) begin
            dm_rdata <= result_reg[dm_addr[2:0]]; // [RULE5]
         end else begin
            case (dm_addr)
               `ACSRC_OFS_TRACK:  dm_rdata <= track_reg;
               `ACSRC_OFS_CTRL:   dm_rdata <= control_reg;
               `ACSRC_OFS_STATUS: dm_rdata <= {11'h000, status_reg};
               `ACSRC_OFS_FAULTS: dm_rdata <= {8'h00, faults_reg};
               default:           dm_rdata <= 16'h0000;
            endcase
         end
      end
   end
endmodule

// >>> logic/acsrc_regs.vh
// Register offsets, field positions, reset values and timing counts for the converter sequencer.
// Behaviour
// RULE1 - Results stored left-aligned twos complement, low zeros
// RULE2 - Zero is 0x0000, clamp 0x7ff0 and 0x8000
// RULE3 - Range fault bit accompanies every result word
// RULE4 - Eight range fault bits, bit n input n
// RULE5 - Software reads fault plus MSB as over/under
// RULE6 - Control bits 4:3 select the four modes
// RULE7 - Reset clears mode bits, simultaneous mode
// RULE8 - Pairs sampled 0/4, 1/5, 2/6, 3/7
// RULE9 - Start rising edge holds first pair at once
// RULE10 - Pipeline latency three and a half cycles
// RULE11 - First input next cycle, second after
// RULE12 - Pair status bit set when pair valid
// RULE13 - Status word cleared when sequence starts
// RULE14 - Interrupt raised when input 7 result valid
// RULE15 - Start edge to interrupt within 49 cycles
// RULE16 - Pairs sampled eight core cycles apart
// RULE17 - Inputs 0-3 bank A, 4-7 bank B
// RULE18 - Converter clock is core clock divided four
// RULE19 - Control bit 0 selects start source
// RULE20 - Idle tracks input 0 into tracking result
// RULE21 - Results written when pipeline output emerges
`ifndef ACSRC_REGS_VH
`define ACSRC_REGS_VH
// Register offsets (word index on the data memory port).
`define ACSRC_OFS_CH0       4'h0
`define ACSRC_OFS_TRACK     4'h8
`define ACSRC_OFS_CTRL      4'h9
`define ACSRC_OFS_STATUS    4'ha
`define ACSRC_OFS_FAULTS    4'hb
// Control word fields.
`define ACSRC_CTRL_SRC_BIT  0
`define ACSRC_CTRL_MODE_LO  3
`define ACSRC_CTRL_MODE_HI  4
`define ACSRC_CTRL_RESET    16'h0000
// Mode codes.
`define ACSRC_MODE_SIMUL    2'h0
`define ACSRC_MODE_SEQ      2'h1
`define ACSRC_MODE_OFFCAL   2'h2
`define ACSRC_MODE_GAINCAL  2'h3
// Status word fields.
`define ACSRC_STAT_TRACK_FAULT 4
// Result coding.
`define ACSRC_POS_CLAMP     16'h7ff0
`define ACSRC_NEG_CLAMP     16'h8000
// Timing: divide ratio, pipeline in converter half-periods, bound in core cycles.
`define ACSRC_DIV           4
`define ACSRC_PIPE_HALF     7
`define ACSRC_MAX_CONV      49
`endif

// >>> logic/acsrc_clkdiv.v
// Divide-by-four converter clock phase generator.
`timescale 1ns/1ns
module acsrc_clkdiv (
   // Clock and reset.
   input  wire       clk,
   input  wire       reset,
   // Phase outputs.
   output reg  [1:0] phase_reg,
   output wire       tick
);
   // Free-running counter; converter clock rate is fixed, software cannot alter it.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         phase_reg <= 2'h0;
      end else begin
         phase_reg <= phase_reg + 2'h1; // [RULE18]
      end
   end

   // One pulse per converter period.
   assign tick = (phase_reg == 2'h3);
endmodule

// >>> logic/acsrc_pipe.v
// Converter core pipeline model: delays a sample by three and a half converter cycles.
`timescale 1ns/1ns
module acsrc_pipe (
   // Clock and reset.
   input  wire        clk,
   input  wire        reset,
   // Input side.
   input  wire        in_valid,
   input  wire [12:0] in_word,
   input  wire [3:0]  in_tag,
   // Output side.
   output wire        out_valid,
   output wire [12:0] out_word,
   output wire [3:0]  out_tag
);
   // Delay line in core cycles; 7 half-periods of two core cycles give 14 cycles.
   localparam DEPTH = 14;
   reg [17:0] stage_reg [0:DEPTH-1];
   integer i;

   // Shift every core cycle; latency is independent of converter phase.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            stage_reg[i] <= 18'h00000;
         end
      end else begin
         stage_reg[0] <= {in_valid, in_tag, in_word}; // [RULE10]
         for (i = 1; i < DEPTH; i = i + 1) begin
            stage_reg[i] <= stage_reg[i-1];
         end
      end
   end

   assign out_valid = stage_reg[DEPTH-1][17];
   assign out_tag   = stage_reg[DEPTH-1][16:13];
   assign out_word  = stage_reg[DEPTH-1][12:0];
endmodule

// >>> verification/acsrc_front_model.sv
// Behavioural converter core that answers with a fixed code for each selected input.
`timescale 1ns/1ns
module acsrc_front_model (
   // Multiplexer selection.
   input  wire logic [1:0]  mux_pair_sel,
   input  wire logic        mux_bank_b,
   // Raw converter answer.
   output logic      [11:0] core_code,
   output logic             core_range_fault
);
   logic [2:0] chan;
   // Bank B carries inputs 4 to 7 and bank A inputs 0 to 3.
   assign chan = {mux_bank_b, mux_pair_sel};
   // Input 1 sits past the top and input 5 below the bottom, so both clamp.
   assign core_range_fault = (chan == 3'h1) || (chan == 3'h5);
   assign core_code = (chan == 3'h1) ? 12'h7ff : (chan == 3'h5) ? 12'h800 :
                      (chan == 3'h2) ? 12'h000 : {1'b0, chan, 8'h21};
endmodule

// >>> verification/acsrc_checker.sv
// Port assertions for the converter sequencer.
`timescale 1ns/1ns
module acsrc_checker (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        reset,
   // Start pins and register port.
   input wire logic        pwm_period_sync,
   input wire logic        external_start_pin,
   input wire logic        dm_sel,
   input wire logic        dm_wr,
   input wire logic [3:0]  dm_addr,
   input wire logic [15:0] dm_wdata,
   input wire logic [15:0] dm_rdata,
   // Front end and interrupt.
   input wire logic        hold_a,
   input wire logic        hold_b,
   input wire logic        core_feed,
   input wire logic [1:0]  front_mode,
   input wire logic        conv_irq
);
   logic src_reg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Shadow of the start source bit, since the checker cannot read the control word.
   always @(posedge clk or posedge reset)
      if (reset) src_reg <= 1'b0;
      else if (dm_sel && dm_wr && dm_addr == 4'h9) src_reg <= dm_wdata[0];
   a_irq_single: assert property (conv_irq |=> !conv_irq)
      else $error("interrupt longer than one cycle");
   a_mode_follow: assert property ((dm_sel && dm_wr && dm_addr == 4'h9) |=> ##1
      front_mode == $past(dm_wdata[4:3], 2)) else $error("mode field not applied");
   a_pwm_bound: assert property (($rose(pwm_period_sync) && !src_reg) |-> ##[1:49] conv_irq)
      else $error("sequence from sync too slow");
   a_ext_bound: assert property (($rose(external_start_pin) && src_reg) |-> ##[1:49] conv_irq)
      else $error("sequence from start pin too slow");
   a_irq_not_early: assert property (($rose(pwm_period_sync) && !src_reg) |=> !conv_irq[*8])
      else $error("interrupt before conversions done");
   a_feed_gap: assert property (core_feed |=> !core_feed[*3])
      else $error("core fed faster than converter clock");
   a_hold_pair: assert property (($rose(hold_a) && front_mode == 2'h0) |-> hold_b)
      else $error("pair not held together");
   a_rdata_stable: assert property (!(dm_sel && !dm_wr) |=> $stable(dm_rdata))
      else $error("read data changed without a read");
endmodule
bind acsrc_top acsrc_checker i_acsrc_checker (.clk(clk), .reset(reset),
   .pwm_period_sync(pwm_period_sync), .external_start_pin(external_start_pin),
   .dm_sel(dm_sel), .dm_wr(dm_wr), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
   .dm_rdata(dm_rdata), .hold_a(hold_a), .hold_b(hold_b), .core_feed(core_feed),
   .front_mode(front_mode), .conv_irq(conv_irq));

// >>> verification/test_adc_sequencer_result_capture.sv
// Self-checking testbench for the converter sequencer and result capture.
`timescale 1ns/1ns
module test_adc_sequencer_result_capture;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        pwm = 1'b0;
   logic        ext = 1'b0;
   logic        dm_sel = 1'b0;
   logic        dm_wr = 1'b0;
   logic [3:0]  dm_addr = 4'h0;
   logic [15:0] dm_wdata = 16'h0000;
   logic [15:0] rd;
   wire  [15:0] dm_rdata;
   wire         hold_a, hold_b, mux_bank_b, core_feed, conv_irq, fault;
   wire  [1:0]  mux_pair_sel, front_mode;
   wire  [11:0] code;
   int          n_fail = 0;
   int          n_tests = 0;
   int          cycles = 0;
   always #20 clk = ~clk;
   acsrc_top i_acsrc_top (.clk(clk), .reset(reset), .pwm_period_sync(pwm),
      .external_start_pin(ext), .dm_sel(dm_sel), .dm_wr(dm_wr), .dm_addr(dm_addr),
      .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .hold_a(hold_a), .hold_b(hold_b),
      .mux_pair_sel(mux_pair_sel), .mux_bank_b(mux_bank_b), .core_feed(core_feed),
      .front_mode(front_mode), .core_code(code), .core_range_fault(fault),
      .conv_irq(conv_irq));
   acsrc_front_model i_acsrc_front_model (.mux_pair_sel(mux_pair_sel),
      .mux_bank_b(mux_bank_b), .core_code(code), .core_range_fault(fault));
   // Same codes as the front model, worked out here independently.
   function automatic logic [11:0] code_of(int n);
      return (n == 1) ? 12'h7ff : (n == 5) ? 12'h800 : (n == 2) ? 12'h000 :
             {1'b0, 3'(n), 8'h21};
   endfunction
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Inputs always move 1 ns after the rising edge.
   task automatic cycle();
      @(posedge clk);
      #1;
   endtask
   // A request stays up after its edge; the next transfer replaces it or bus_idle drops it.
   task automatic wr(logic [3:0] a, logic [15:0] d);
      {dm_sel, dm_wr, dm_addr, dm_wdata} = {2'b11, a, d};
      cycle();
   endtask
   // Read data is registered, so it is taken after the edge that took the request.
   task automatic rd_reg(logic [3:0] a);
      {dm_sel, dm_wr, dm_addr} = {2'b10, a};
      cycle();
      rd = dm_rdata;
   endtask
   task automatic bus_idle();
      {dm_sel, dm_wr} = 2'b00;
   endtask
   task automatic t_reset_values();
      rd_reg(4'h9);
      check("control", rd, 16'h0000);
      rd_reg(4'ha);
      check("status", rd, 16'h0000);
      rd_reg(4'hb);
      check("faults", rd, 16'h0000);
   endtask
   // Starts one sequence from the chosen pin and times its interrupt.
   task automatic run_seq(logic src);
      int k;
      if (src) ext = 1'b1;
      else pwm = 1'b1;
      repeat (7) cycle();
      rd_reg(4'ha);
      check("status at start", {12'h000, rd[3:0]}, 16'h0000);
      bus_idle();
      for (k = 8; k < 80 && conv_irq !== 1'b1; k++) cycle();
      check("interrupt in time", 16'(k <= 49), 16'h0001);
      {pwm, ext} = 2'b00;
   endtask
   task automatic t_mode_sequences();
      int m;
      int n;
      for (m = 0; m < 4; m++) begin
         wr(4'h9, 16'hffe6 | 16'(m << 3) | 16'(m & 1));
         rd_reg(4'h9);
         check("control", rd, 16'(m << 3) | 16'(m & 1));
         check("front mode", {14'h0, front_mode}, 16'(m));
         run_seq(m[0]);
         rd_reg(4'ha);
         check("pair status", {12'h000, rd[3:0]}, 16'h000f);
         for (n = 0; n < 8; n++) begin
            rd_reg(4'(n));
            check("result", rd, {code_of(n), 4'h0});
            // Input 1 is over the top (MSB clear), input 5 under the bottom (MSB set).
            if (n == 1 || n == 5) check("range class", {15'h0, rd[15]}, 16'(n == 5));
         end
         rd_reg(4'hb);
         check("faults", rd, 16'h0022);
      end
   endtask
   task automatic t_tracking();
      int k;
      int irqs = 0;
      bus_idle();
      for (k = 0; k < 24; k++) begin
         cycle();
         if (conv_irq === 1'b1) irqs++;
      end
      check("tracking irqs", 16'(irqs), 16'h0000);
      rd_reg(4'h8);
      check("tracking", rd, {code_of(0), 4'h0});
      rd_reg(4'ha);
      check("tracking fault", {15'h0, rd[4]}, 16'h0000);
   endtask
   // Results are read only; a write there must leave them alone.
   task automatic t_refused_write();
      wr(4'h0, 16'h5555);
      rd_reg(4'h0);
      check("result after write", rd, {code_of(0), 4'h0});
   endtask
   // A hang is cut short well beyond the few hundred cycles the tests need.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      t_reset_values();
      t_mode_sequences();
      t_tracking();
      t_refused_write();
      test_done();
   end
endmodule
